// [pkg/lga_pkg.sv]
package lga_pkg;
  localparam int NUM_EL   = 16;
  localparam int BLK_SIZE = 8;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int SYNC_W   = 20;

  localparam logic [ADDR_W-1:0] OFS_ELEM = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ELEM_LAST = 8'h3c;
  localparam logic [ADDR_W-1:0] OFS_CLK  = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_IRQ  = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_ADC  = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_DIN  = 8'h4c;
  localparam logic [ADDR_W-1:0] OFS_OUT  = 8'h50;

  localparam int ELEM_W    = 11;
  localparam int CLK1_LO   = 4;
  localparam int CLK0_LO   = 0;
  localparam int IRQ1_LO   = 8;
  localparam int IRQ0_LO   = 0;
  localparam int ROUTE_W   = 5;

  localparam logic [ELEM_W-1:0]  ELEM_RST  = 11'h000;
  localparam logic [ROUTE_W-1:0] ROUTE_RST = 5'h00;
  localparam logic [NUM_EL-1:0]  DIN_RST   = 16'h0000;

  typedef enum logic [2:0] {
    LGA_CLK_GPIO_A = 3'h0,
    LGA_CLK_GPIO_B = 3'h1,
    LGA_CLK_GPIO_C = 3'h2,
    LGA_CLK_HOST   = 3'h3,
    LGA_CLK_OTHER  = 3'h4,
    LGA_CLK_TMR1   = 3'h5,
    LGA_CLK_TMR4   = 3'h6,
    LGA_CLK_RSVD   = 3'h7
  } lga_clk_sel_t;

  typedef struct packed {
    logic [1:0] fb0_sel;
    logic [1:0] fb1_sel;
    logic       use_fb1;
    logic       use_pin;
    logic [3:0] lut;
    logic       bypass;
  } lga_elem_t;

  typedef struct packed {
    logic       en;
    logic [3:0] src;
  } lga_route_t;
endpackage : lga_pkg

// [core/lga_logic_array.sv]
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
// Summary of operation
// R1: sixteen elements, two blocks of eight
// R2: each element: two-input table plus optional flop
// R3: element 7 of each block feeds other block
// R4: sixteen input pins, sixteen output pins
// R5: one fixed input and output pin per element
// R6: bits 10-9 pick first feedback source
// R7: bits 8-7 pick second feedback source
// R8: bit 6 picks feedback or software bit
// R9: bit 5 picks input pin or feedback
// R10: bits 4-1 give the lookup function
// R11: bit 0 bypasses flop, resets cleared
// R12: bits 6-4 pick block 1 clock
// R13: bits 2-0 pick block 0 clock
// R14: bit 12 enables second interrupt output
// R15: bits 11-8 pick second interrupt source
// R16: outputs reach interrupts, adc, register, pins
// R17: readback register follows element outputs always
// R18: pins join array only when gpio selects
// R19: bit 4, bits 3-0 drive first interrupt
// R20: adc start enable and source select
// R21: flops capture on selected block clock edge
module lga_logic_array (
  input  wire logic                           clock_i,
  input  wire logic                           reset_n_i,
  input  wire logic [lga_pkg::ADDR_W-1:0]     addr_i,
  input  wire logic [lga_pkg::DATA_W-1:0]     wdata_i,
  input  wire logic                           wr_i,
  input  wire logic                           rd_i,
  output logic      [lga_pkg::DATA_W-1:0]     rdata_o,
  input  wire logic [lga_pkg::NUM_EL-1:0]     pin_in_i,
  input  wire logic [lga_pkg::NUM_EL-1:0]     in_func_sel_i,
  input  wire logic [lga_pkg::NUM_EL-1:0]     out_func_sel_i,
  output logic      [lga_pkg::NUM_EL-1:0]     pin_out_o,
  output logic      [lga_pkg::NUM_EL-1:0]     pin_out_oe_n_o,
  input  wire logic [2:0]                     gpio_clk_i,
  input  wire logic                           other_core_clock_i,
  input  wire logic                           timer1_ovf_i,
  input  wire logic                           timer4_ovf_i,
  output logic                                irq0_o,
  output logic                                irq1_o,
  output logic                                adc_conversion_start_o
);
  import lga_pkg::*;

  lga_elem_t             element_config [NUM_EL];
  logic [7:0]            block_clock_select;
  lga_route_t            irq0_route;
  lga_route_t            irq1_route;
  lga_route_t            adc_start_select;
  logic [NUM_EL-1:0]     software_data_input;
  logic [NUM_EL-1:0]     element_output_readback;

  logic [SYNC_W-1:0]     sync1;
  logic [SYNC_W-1:0]     sync2;
  logic [SYNC_W-1:0]     sync3;
  logic [SYNC_W-1:0]     stable;
  logic [SYNC_W-1:0]     rise;

  logic [NUM_EL-1:0]     el_ff;
  logic [NUM_EL-1:0]     el_out;
  logic [NUM_EL-1:0]     el_fb;
  logic [NUM_EL-1:0]     lut_out;
  logic [NUM_EL-1:0]     pin_eff;
  logic [1:0]            blk_en;

  logic                  elem_hit;
  logic [3:0]            elem_idx;

  // first feedback mux: element 0 of each block takes the other block's
  // element 7 on code 00, every other choice is an even element
  function automatic logic [3:0] fb0_src(input int el,
                                         input logic [1:0] sel);
    logic [3:0] base;
    base = (el >= BLK_SIZE) ? 4'h8 : 4'h0;
    if ((el % BLK_SIZE) == 0 && sel == 2'h0) begin
      fb0_src = base ^ 4'hf; // see R3 see R6
    end else begin
      fb0_src = base + {1'b0, sel, 1'b0}; // see R6
    end
  endfunction : fb0_src

  function automatic logic [3:0] fb1_src(input int el,
                                         input logic [1:0] sel);
    logic [3:0] base;
    base = (el >= BLK_SIZE) ? 4'h9 : 4'h1;
    fb1_src = base + {1'b0, sel, 1'b0}; // see R7
  endfunction : fb1_src

  function automatic logic clk_pick(input logic [2:0] code,
                                    input logic [SYNC_W-1:0] r);
    unique case (lga_clk_sel_t'(code))
      LGA_CLK_GPIO_A: clk_pick = r[16];
      LGA_CLK_GPIO_B: clk_pick = r[17];
      LGA_CLK_GPIO_C: clk_pick = r[18];
      LGA_CLK_HOST:   clk_pick = 1'b1;
      LGA_CLK_OTHER:  clk_pick = r[19];
      LGA_CLK_TMR1:   clk_pick = timer1_ovf_i;
      LGA_CLK_TMR4:   clk_pick = timer4_ovf_i;
      LGA_CLK_RSVD:   clk_pick = 1'b0;
    endcase
  endfunction : clk_pick

  // register access
  assign elem_hit = (addr_i <= OFS_ELEM_LAST);
  assign elem_idx = addr_i[5:2];

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NUM_EL; i++) begin
        element_config[i] <= ELEM_RST; // see R11
      end
    end else if (wr_i && elem_hit) begin
      element_config[elem_idx] <= lga_elem_t'(wdata_i[ELEM_W-1:0]);
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      block_clock_select  <= 8'h00;
      irq0_route          <= ROUTE_RST;
      irq1_route          <= ROUTE_RST;
      adc_start_select    <= ROUTE_RST;
      software_data_input <= DIN_RST;
    end else if (wr_i) begin
      unique case (addr_i)
        OFS_CLK: begin
          block_clock_select <= {1'b0, wdata_i[CLK1_LO+:3],
                                 1'b0, wdata_i[CLK0_LO+:3]};
        end
        OFS_IRQ: begin
          irq1_route <= lga_route_t'(wdata_i[IRQ1_LO+:ROUTE_W]);
          irq0_route <= lga_route_t'(wdata_i[IRQ0_LO+:ROUTE_W]);
        end
        OFS_ADC: begin
          adc_start_select <= lga_route_t'(wdata_i[ROUTE_W-1:0]);
        end
        OFS_DIN: begin
          software_data_input <= wdata_i[NUM_EL-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      if (elem_hit) begin
        rdata_o <= {21'h000000, element_config[elem_idx]};
      end else begin
        unique case (addr_i)
          OFS_CLK: rdata_o <= {24'h000000, block_clock_select};
          OFS_IRQ: rdata_o <= {19'h00000, irq1_route, 3'h0, irq0_route};
          OFS_ADC: rdata_o <= {27'h0000000, adc_start_select};
          OFS_DIN: rdata_o <= {16'h0000, software_data_input};
          OFS_OUT: rdata_o <= {16'h0000, element_output_readback};
          default: rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // pins and foreign clocks: three flops, a level moves once 2 and 3 agree
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1  <= '0;
      sync2  <= '0;
      sync3  <= '0;
      stable <= '0;
    end else begin
      sync1  <= {other_core_clock_i, gpio_clk_i, pin_in_i};
      sync2  <= sync1;
      sync3  <= sync2;
      stable <= (sync2 & sync3) | (stable & (sync2 | sync3));
    end
  end

  assign rise = sync2 & sync3 & ~stable;

  // a pin not handed to the array reads as zero inside it
  assign pin_eff = stable[NUM_EL-1:0] & in_func_sel_i; // see R18 see R4

  // feedback comes from the registered outputs: bypassed chains would
  // otherwise form combinational loops, at the cost of one cycle per hop
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      el_fb <= '0;
    end else begin
      el_fb <= el_out;
    end
  end

  always_comb begin
    logic a;
    logic b;
    a = 1'b0;
    b = 1'b0;
    for (int i = 0; i < NUM_EL; i++) begin
      a = element_config[i].use_pin ? pin_eff[i] // see R5 see R9
        : el_fb[fb0_src(i, element_config[i].fb0_sel)];
      b = element_config[i].use_fb1 // see R8
        ? el_fb[fb1_src(i, element_config[i].fb1_sel)]
        : software_data_input[i];
      lut_out[i] = element_config[i].lut[{a, b}]; // see R2 see R10
      el_out[i]  = element_config[i].bypass ? lut_out[i] : el_ff[i]; // see R11
    end
  end

  // one clock only: the chosen source becomes a per-block enable, one cycle per edge or pulse, or held every cycle for the host clock
  always_comb begin
    blk_en[0] = clk_pick(block_clock_select[CLK0_LO+:3], rise); // see R13
    blk_en[1] = clk_pick(block_clock_select[CLK1_LO+:3], rise); // see R12
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      el_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_EL; i++) begin
        if (blk_en[i / BLK_SIZE]) begin
          el_ff[i] <= lut_out[i]; // see R1 see R21
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      element_output_readback <= '0;
    end else begin
      element_output_readback <= el_out; // see R17
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq0_o                 <= 1'b0;
      irq1_o                 <= 1'b0;
      adc_conversion_start_o <= 1'b0;
    end else begin
      irq0_o <= irq0_route.en & el_out[irq0_route.src]; // see R19 see R16
      irq1_o <= irq1_route.en & el_out[irq1_route.src]; // see R14 see R15
      adc_conversion_start_o <= adc_start_select.en
                                & el_out[adc_start_select.src]; // see R20
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_out_o      <= '0;
      pin_out_oe_n_o <= '1;
    end else begin
      pin_out_o      <= el_out & out_func_sel_i; // see R16
      pin_out_oe_n_o <= ~out_func_sel_i; // see R18
    end
  end

  // read data reflect the readback word as it stood at the strobe
  readback_track_a: assert property (@(posedge clock_i) // see R17
      disable iff (!reset_n_i)
      rd_i && addr_i == OFS_OUT |=>
      rdata_o == {16'h0000, $past(element_output_readback)})
    else $error("readback word wrong");

  readback_follow_a: assert property (@(posedge clock_i) // see R17
      disable iff (!reset_n_i)
      1'b1 |=> element_output_readback == $past(el_out))
    else $error("readback lags element outputs");

  irq1_gate_a: assert property (@(posedge clock_i) // see R14
      disable iff (!reset_n_i)
      !irq1_route.en |=> !irq1_o)
    else $error("irq1 active while disabled");

  irq1_source_a: assert property (@(posedge clock_i) // see R15
      disable iff (!reset_n_i)
      irq1_route.en |=> irq1_o == $past(el_out[irq1_route.src]))
    else $error("irq1 follows wrong element");

  irq0_source_a: assert property (@(posedge clock_i) // see R19
      disable iff (!reset_n_i) 1'b1 |=>
      irq0_o == ($past(irq0_route.en) && $past(el_out[irq0_route.src])))
    else $error("irq0 wrong");

  irq0_gate_a: assert property (@(posedge clock_i) // see R19
      disable iff (!reset_n_i)
      !irq0_route.en |=> !irq0_o)
    else $error("irq0 active while disabled");

  adc_start_a: assert property (@(posedge clock_i) // see R20
      disable iff (!reset_n_i)
      !adc_start_select.en ##1 !adc_start_select.en |-> !adc_conversion_start_o)
    else $error("adc start while disabled");

  block0_hold_a: assert property (@(posedge clock_i) // see R21
      disable iff (!reset_n_i)
      !blk_en[0] |=> el_ff[7:0] == $past(el_ff[7:0]))
    else $error("block 0 flops moved without clock");

  block1_hold_a: assert property (@(posedge clock_i) // see R21
      disable iff (!reset_n_i)
      !blk_en[1] |=> el_ff[15:8] == $past(el_ff[15:8]))
    else $error("block 1 flops moved without clock");

  block0_capture_a: assert property (@(posedge clock_i) // see R13
      disable iff (!reset_n_i)
      blk_en[0] |=> el_ff[7:0] == $past(lut_out[7:0]))
    else $error("block 0 capture wrong");

  block1_capture_a: assert property (@(posedge clock_i) // see R12
      disable iff (!reset_n_i)
      blk_en[1] |=> el_ff[15:8] == $past(lut_out[15:8]))
    else $error("block 1 capture wrong");

  host_clock_a: assert property (@(posedge clock_i) // see R13
      disable iff (!reset_n_i)
      block_clock_select[2:0] == 3'h3 |-> blk_en[0])
    else $error("host clock not every cycle");

  reserved_clock_a: assert property (@(posedge clock_i) // see R12
      disable iff (!reset_n_i)
      block_clock_select[6:4] == 3'h7 |-> !blk_en[1])
    else $error("reserved clock code captured");

  bypass_path_a: assert property (@(posedge clock_i) // see R11
      disable iff (!reset_n_i)
      element_config[0].bypass |-> el_out[0] == lut_out[0])
    else $error("bypass not taken");

  flop_path_a: assert property (@(posedge clock_i) // see R11
      disable iff (!reset_n_i)
      !element_config[0].bypass |-> el_out[0] == el_ff[0])
    else $error("flop output not used");

  // a level change is taken only once the last two stages agree
  sync_level_a: assert property (@(posedge clock_i) // see R4
      disable iff (!reset_n_i)
      sync2 == sync3 |=> stable == $past(sync2))
    else $error("synchronised level wrong");

  pin_gate_a: assert property (@(posedge clock_i) // see R18
      disable iff (!reset_n_i)
      !in_func_sel_i[0] |-> !pin_eff[0])
    else $error("unselected pin reached array");

  fb_delay_a: assert property (@(posedge clock_i) // see R3
      disable iff (!reset_n_i)
      1'b1 |=> el_fb == $past(el_out))
    else $error("feedback not one cycle late");

  cross_link_a: assert property (@(posedge clock_i) // see R3
      disable iff (!reset_n_i)
      element_config[0].fb0_sel == 2'h0 && !element_config[0].use_pin &&
      element_config[0].bypass && element_config[0].lut == 4'hc
      |-> el_out[0] == el_fb[15])
    else $error("element 0 not fed from element 15");

  soft_input_a: assert property (@(posedge clock_i) // see R8
      disable iff (!reset_n_i)
      !element_config[1].use_fb1 && element_config[1].bypass &&
      element_config[1].lut == 4'ha |-> el_out[1] == software_data_input[1])
    else $error("software bit not used");

  pin_path_a: assert property (@(posedge clock_i) // see R9
      disable iff (!reset_n_i)
      element_config[2].use_pin && element_config[2].bypass &&
      element_config[2].lut == 4'hc |-> el_out[2] == pin_eff[2])
    else $error("input pin not used");

  oe_follow_a: assert property (@(posedge clock_i) // see R18
      disable iff (!reset_n_i)
      1'b1 |=> pin_out_oe_n_o == ~$past(out_func_sel_i))
    else $error("output enable wrong");

  pin_drive_a: assert property (@(posedge clock_i) // see R18
      disable iff (!reset_n_i)
      !out_func_sel_i[3] |=> pin_out_oe_n_o[3] && !pin_out_o[3])
    else $error("pin driven while not selected");
endmodule : lga_logic_array

// [dv/lga_far_side.sv]
`timescale 1ns/10ps
// far side: gpio pads, spare clock sources and timer overflow pulses
module lga_far_side (
  input  wire logic [lga_pkg::NUM_EL-1:0] pin_level_i,
  input  wire logic                       t1_req_i,
  input  wire logic [2:0]                 gclk_req_i,
  output logic      [lga_pkg::NUM_EL-1:0] pin_in_o,
  output logic      [2:0]                 gpio_clk_o,
  output logic                            other_clk_o,
  output logic                            timer1_ovf_o,
  output logic                            timer4_ovf_o
);
  import lga_pkg::*;
  assign pin_in_o     = pin_level_i;
  // unused clock sources stand still, so a wrong select never captures
  assign gpio_clk_o   = gclk_req_i;
  assign other_clk_o  = 1'b0;
  assign timer1_ovf_o = t1_req_i;
  assign timer4_ovf_o = 1'b0;
endmodule : lga_far_side

// [dv/lga_logic_array_tb.sv]
`timescale 1ns/10ps
module lga_logic_array_tb;
  import lga_pkg::*;
  logic              clock_i   = 1'b0;
  logic              reset_n_i = 1'b0;
  logic [ADDR_W-1:0] addr_i    = 8'h00;
  logic [DATA_W-1:0] wdata_i   = 32'h0;
  logic              wr_i      = 1'b0;
  logic              rd_i      = 1'b0;
  logic              t1_req    = 1'b0;
  logic [2:0]        gclk_req  = 3'h0;
  logic [NUM_EL-1:0] pin_lvl   = 16'h0000;
  logic [NUM_EL-1:0] in_sel    = 16'hffff;
  logic [NUM_EL-1:0] out_sel   = 16'hffff;
  logic [DATA_W-1:0] rdata_o;
  logic [NUM_EL-1:0] pin_in, pin_out, oe_n;
  logic [2:0]        gclk;
  logic              other_core_clock, t1, t4, irq0, irq1, adc;
  logic [DATA_W-1:0] d;
  int                miscompares = 0;
  int                n_compared  = 0;

  always #50 clock_i = ~clock_i;

  lga_far_side far (.pin_level_i(pin_lvl), .t1_req_i(t1_req),
    .gclk_req_i(gclk_req),
    .pin_in_o(pin_in), .gpio_clk_o(gclk), .other_clk_o(other_core_clock),
    .timer1_ovf_o(t1), .timer4_ovf_o(t4));

  lga_logic_array uut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .pin_in_i(pin_in), .in_func_sel_i(in_sel),
    .out_func_sel_i(out_sel), .pin_out_o(pin_out),
    .pin_out_oe_n_o(oe_n), .gpio_clk_i(gclk),
    .other_core_clock_i(other_core_clock), .timer1_ovf_i(t1),
    .timer4_ovf_i(t4), .irq0_o(irq0), .irq1_o(irq1),
    .adc_conversion_start_o(adc));

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  // element word: fb0, fb1, use fb1, use pin, table, bypass
  task automatic el(input int i, input logic [1:0] f0, input logic [1:0] f1,
                    input logic u1, input logic up, input logic [3:0] lut,
                    input logic byp);
    wr(8'(4 * i), {21'h0, f0, f1, u1, up, lut, byp});
  endtask : el

  task automatic t_reset();
    logic [7:0] adr [8] = '{8'h00, 8'h3c, 8'h40, 8'h44, 8'h48, 8'h4c,
                            8'h50, 8'h7c};
    foreach (adr[k]) begin
      rd(adr[k]);
      chk(d, 32'h0);
    end
    $display("test reset done");
  endtask : t_reset

  task automatic t_lut();
    wr(OFS_CLK, 32'h33);
    for (int c = 0; c < 16; c++) begin
      el(0, 2'h0, 2'h0, 1'b0, 1'b1, 4'(c), 1'b1);
      for (int ab = 0; ab < 4; ab++) begin
        pin_lvl[0] <= ab[1];
        wr(OFS_DIN, {31'h0, ab[0]});
        cyc(8);
        rd(OFS_OUT);
        chk(d[0], c[ab]);
        chk(pin_out[0], c[ab]);
      end
    end
    $display("test lut done");
  endtask : t_lut

  task automatic t_feedback();
    el(15, 2'h0, 2'h0, 1'b0, 1'b0, 4'hf, 1'b1);
    el(7, 2'h0, 2'h0, 1'b0, 1'b0, 4'hf, 1'b1);
    el(2, 2'h0, 2'h0, 1'b0, 1'b0, 4'hf, 1'b1);
    el(0, 2'h0, 2'h0, 1'b0, 1'b0, 4'hc, 1'b1);
    el(8, 2'h0, 2'h0, 1'b0, 1'b0, 4'hc, 1'b1);
    el(3, 2'h1, 2'h0, 1'b0, 1'b0, 4'hc, 1'b1);
    el(9, 2'h0, 2'h3, 1'b1, 1'b0, 4'ha, 1'b1);
    cyc(6);
    rd(OFS_OUT);
    chk(d[15:0], 16'h838d);
    el(15, 2'h0, 2'h0, 1'b0, 1'b0, 4'h0, 1'b1);
    cyc(6);
    rd(OFS_OUT);
    chk(d[15:0], 16'h018c);
    $display("test feedback done");
  endtask : t_feedback

  task automatic t_route();
    el(5, 2'h0, 2'h0, 1'b0, 1'b0, 4'hf, 1'b1);
    wr(OFS_IRQ, 32'h1500);
    cyc(3);
    chk({irq1, irq0}, 2'b10);
    wr(OFS_IRQ, 32'h0015);
    cyc(3);
    chk({irq1, irq0}, 2'b01);
    wr(OFS_IRQ, 32'h1616);
    cyc(3);
    chk({irq1, irq0}, 2'b00);
    wr(OFS_ADC, 32'h15);
    cyc(3);
    chk(adc, 1'b1);
    wr(OFS_ADC, 32'h05);
    cyc(3);
    chk(adc, 1'b0);
    $display("test route done");
  endtask : t_route

  task automatic t_clock();
    wr(OFS_CLK, 32'h37);
    el(4, 2'h0, 2'h0, 1'b0, 1'b0, 4'hf, 1'b0);
    el(11, 2'h0, 2'h0, 1'b0, 1'b0, 4'hf, 1'b0);
    cyc(6);
    rd(OFS_OUT);
    chk(d[4], 1'b0);
    chk(d[11], 1'b1);
    wr(OFS_CLK, 32'h35);
    cyc(6);
    rd(OFS_OUT);
    chk(d[4], 1'b0);
    t1_req <= 1'b1;
    cyc(1);
    t1_req <= 1'b0;
    cyc(4);
    rd(OFS_OUT);
    chk(d[4], 1'b1);
    el(6, 2'h0, 2'h0, 1'b0, 1'b0, 4'hf, 1'b0);
    wr(OFS_CLK, 32'h31);
    cyc(6);
    rd(OFS_OUT);
    chk(d[6], 1'b0);
    gclk_req[1] <= 1'b1;
    cyc(8);
    rd(OFS_OUT);
    chk(d[6], 1'b1);
    $display("test clock done");
  endtask : t_clock

  task automatic t_gpio();
    wr(OFS_CLK, 32'h33);
    el(0, 2'h0, 2'h0, 1'b0, 1'b1, 4'hc, 1'b1);
    in_sel[0]  <= 1'b0;
    out_sel[0] <= 1'b0;
    pin_lvl[0] <= 1'b1;
    cyc(8);
    rd(OFS_OUT);
    chk(d[0], 1'b0);
    chk({oe_n[0], pin_out[0]}, 2'b10);
    $display("test gpio done");
  endtask : t_gpio

  initial begin
    cyc(12);
    reset_n_i <= 1'b1;
    t_reset();
    t_lut();
    t_feedback();
    t_route();
    t_clock();
    t_gpio();
    give_verdict();
  end

  // the tests need about 1000 cycles; allow twenty times that
  initial begin
    #2000000;
    miscompares++;
    give_verdict();
  end
endmodule : lga_logic_array_tb
